// File: shared/tkd_pkg.sv
// Operation
// (RULE1) Twenty-four setup bytes, one per key, at addresses 141 to 164.
// (RULE2) Touched when filtered signal falls below reference minus threshold.
// (RULE3) Threshold levels are recomputed whenever the reference moves.
// (RULE4) Signal above reference plus positive threshold recalibrates key.
// (RULE5) Positive hysteresis is fixed at one eighth of positive threshold.
// (RULE6) Negative and positive thresholds share one three-bit field per key.
// (RULE7) Threshold code defaults to 3 (10 counts); codes 2 to 4 give 8-12.
// (RULE8) Reference slews to signal; paused past threshold or in detection.
// (RULE9) Falling drift rate is per key; rising rate is one global setting.
// (RULE10) Per-key falling drift rate defaults to code 4, one count per 2 s.
// (RULE11) Global rising drift rate defaults to code 4, one count per 2 s.
// (RULE12) Host should make rising drift faster than falling drift.
// (RULE13) A burst repeats X pulse with matching Y line enabled a fixed count.
// (RULE14) Burst code 0..3 selects 16, 32, 48 or 64 pulses.
// (RULE15) Burst code defaults to 2, which is 48 pulses.
// (RULE16) Host should keep bursts short and negative threshold above 6.
// (RULE17) Setups writable only after 0xFE to address 140; any read relocks.
// (RULE18) Setup writes go to non-volatile memory and take effect at once.
// (RULE19) Setup byte: burst code 7:6, falling drift 5:3, threshold 2:0.
package tkd_pkg;

    localparam int KEYS = 24;
    localparam int SIG_W = 12;
    localparam logic [7:0] CMD_ADDR = 8'h8C;
    localparam logic [7:0] CMD_UNLOCK = 8'hFE;
    localparam logic [7:0] SETUP_BASE = 8'h8D;
    localparam logic [7:0] SETUP_LAST = 8'hA4;
    localparam logic [7:0] RISE_ADDR = 8'hED;
    localparam logic [7:0] SETUP_RESET = 8'hA3;
    localparam logic [2:0] RISE_RESET = 3'h4;
    localparam int BL_MSB = 7;
    localparam int BL_LSB = 6;
    localparam int DR_MSB = 5;
    localparam int DR_LSB = 3;
    localparam int TH_MSB = 2;
    localparam int TH_LSB = 0;
    localparam int X_LINES = 8;
    localparam int Y_LINES = 3;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [3:0] X_PERIOD = 4'h4;
    localparam logic [3:0] X_HIGH = 4'h1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tkd_reg_req_t;

    typedef struct packed {
        logic stb;
        logic [7:0] addr;
        logic [7:0] data;
    } tkd_nv_write_t;

    // Threshold translation: 4 + 2 * code counts.
    function automatic logic [SIG_W-1:0] tkd_thr_counts(
        input logic [2:0] code);
        return 12'h004 + {8'h00, code, 1'b0}; // [RULE7]
    endfunction : tkd_thr_counts

    // Drift interval in 100 ms ticks per count of reference adjustment.
    function automatic logic [15:0] tkd_drift_ticks(input logic [2:0] code);
        case (code)
            3'h0: return 16'h0002;
            3'h1: return 16'h0005;
            3'h2: return 16'h000A;
            3'h3: return 16'h000F;
            3'h4: return 16'h0014; // [RULE10] [RULE11]
            3'h5: return 16'h0021;
            3'h6: return 16'h0032;
            default: return 16'h0064;
        endcase
    endfunction : tkd_drift_ticks

    function automatic logic [6:0] tkd_burst_pulses(input logic [1:0] code);
        return {1'b0, code, 4'h0} + 7'h10; // [RULE14]
    endfunction : tkd_burst_pulses

endpackage : tkd_pkg

// File: rtl/tkd_burst.sv
`timescale 1ns/100ps
module tkd_burst
    import tkd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic [1:0] code_i,
    output logic x_pulse_o,
    output logic y_enable_o,
    output logic done_o
);

    logic [6:0] left;
    logic [3:0] phase;
    logic busy;
    wire last_phase = (phase == X_PERIOD - 4'h1);

    // The Y line stays enabled across the whole burst so each X edge's
    // charge is captured; X pulses once per period.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            left <= 7'h00;
            phase <= 4'h0;
            busy <= 1'b0;
            done_o <= 1'b0;
            x_pulse_o <= 1'b0;
            y_enable_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (!busy && start_i) begin
                left <= tkd_burst_pulses(code_i); // [RULE14]
                phase <= 4'h0;
                busy <= 1'b1;
                y_enable_o <= 1'b1; // [RULE13]
            end else if (busy) begin
                phase <= last_phase ? 4'h0 : phase + 4'h1;
                x_pulse_o <= (phase < X_HIGH); // [RULE13]
                if (last_phase) begin
                    left <= left - 7'h01;
                    if (left == 7'h01) begin
                        busy <= 1'b0;
                        y_enable_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                end
            end
        end
    end

endmodule : tkd_burst

// File: rtl/tkd_touch_key.sv
`timescale 1ns/100ps
module tkd_touch_key
    import tkd_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input tkd_reg_req_t reg_req_i,
    input wire logic [SIG_W-1:0] signal_i,
    output logic [7:0] reg_rdata_o,
    output logic setups_unlocked_o,
    output tkd_nv_write_t nv_write_o,
    output logic [X_LINES-1:0] x_drive_o,
    output logic [Y_LINES-1:0] y_enable_o,
    output logic [KEYS-1:0] touch_o
);

    // ------------------------------------------------------------
    // Setup storage and write protection
    // ------------------------------------------------------------
    logic [7:0] setup [KEYS];
    logic [2:0] rising_drift_rate;
    logic unlocked;

    wire in_setup = (reg_req_i.addr >= SETUP_BASE) &&
                    (reg_req_i.addr <= SETUP_LAST); // [RULE1]
    wire [7:0] setup_off = reg_req_i.addr - SETUP_BASE;
    wire [4:0] setup_idx = setup_off[4:0];
    wire wr_setup = reg_req_i.wr && unlocked && in_setup; // [RULE17]
    wire wr_rise = reg_req_i.wr && unlocked &&
                   (reg_req_i.addr == RISE_ADDR); // [RULE17]
    wire wr_unlock = reg_req_i.wr && (reg_req_i.addr == CMD_ADDR) &&
                     (reg_req_i.wdata == CMD_UNLOCK); // [RULE17]
    wire [7:0] rd_mux = in_setup ? setup[setup_idx] :
                        (reg_req_i.addr == RISE_ADDR) ?
                        {5'h00, rising_drift_rate} : 8'h00;

    // A read in the same cycle as the unlock command leaves the block
    // locked: protection errs on the safe side.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            unlocked <= 1'b0;
            rising_drift_rate <= RISE_RESET; // [RULE11]
            reg_rdata_o <= 8'h00;
            nv_write_o <= '0;
        end else begin
            if (reg_req_i.rd) begin
                unlocked <= 1'b0; // [RULE17]
                reg_rdata_o <= rd_mux;
            end else if (wr_unlock) begin
                unlocked <= 1'b1;
            end
            if (wr_rise) begin
                rising_drift_rate <= reg_req_i.wdata[2:0]; // [RULE9]
            end
            nv_write_o.stb <= wr_setup || wr_rise; // [RULE18]
            nv_write_o.addr <= reg_req_i.addr;
            nv_write_o.data <= reg_req_i.wdata;
        end
    end

    // Setups act on the very next use of the key; no restart is forced.
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < KEYS; i++) begin
            if (reset_i) begin
                setup[i] <= SETUP_RESET; // [RULE7] [RULE10] [RULE15]
            end else if (wr_setup && setup_idx == i[4:0]) begin
                setup[i] <= reg_req_i.wdata; // [RULE18]
            end
        end
    end

    assign setups_unlocked_o = unlocked;

    // ------------------------------------------------------------
    // Drift time base
    // ------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic [15:0] now_ticks;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tick_cnt <= 32'h0;
            now_ticks <= 16'h0000;
        end else if (tick_cnt == 32'(TICK_LEN - 1)) begin
            tick_cnt <= 32'h0;
            now_ticks <= now_ticks + 16'h0001;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Key scan sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_START, ST_BURST, ST_EVAL} tkd_state_t;
    tkd_state_t state;
    logic [4:0] key;
    logic [SIG_W-1:0] sig;
    logic burst_start;
    logic burst_x;
    logic burst_y;
    logic burst_done;

    wire [7:0] cur_setup = setup[key];
    wire [1:0] cur_bl = cur_setup[BL_MSB:BL_LSB]; // [RULE19]
    wire [2:0] cur_fall = cur_setup[DR_MSB:DR_LSB]; // [RULE19]
    wire [2:0] cur_thr = cur_setup[TH_MSB:TH_LSB]; // [RULE19]

    tkd_burst u_burst (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .start_i(burst_start),
        .code_i(cur_bl),
        .x_pulse_o(burst_x),
        .y_enable_o(burst_y),
        .done_o(burst_done)
    );

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state <= ST_START;
            key <= 5'h00;
            sig <= '0;
            burst_start <= 1'b0;
        end else begin
            burst_start <= 1'b0;
            case (state)
                ST_START: begin
                    burst_start <= 1'b1;
                    state <= ST_BURST;
                end
                ST_BURST: begin
                    if (burst_done) begin
                        sig <= signal_i;
                        state <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    key <= (key == 5'(KEYS - 1)) ? 5'h00 : key + 5'h01;
                    state <= ST_START;
                end
                default: state <= ST_START;
            endcase
        end
    end

    // Key k sits on X line k mod 8 and Y line k div 8.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            x_drive_o <= '0;
            y_enable_o <= '0;
        end else begin
            x_drive_o <= burst_x ? 8'(1 << key[2:0]) : 8'h00; // [RULE13]
            y_enable_o <= burst_y ? 3'(1 << key[4:3]) : 3'h0; // [RULE13]
        end
    end

    // ------------------------------------------------------------
    // Reference, thresholds and drift
    // ------------------------------------------------------------
    logic [SIG_W-1:0] ref_lvl [KEYS];
    logic [15:0] stamp [KEYS];
    logic [KEYS-1:0] cal_done;
    logic [KEYS-1:0] pos_pend;

    wire [SIG_W-1:0] cur_ref = ref_lvl[key];
    wire [SIG_W-1:0] thr = tkd_thr_counts(cur_thr); // [RULE6]
    wire [SIG_W-1:0] hyst = {3'h0, thr[SIG_W-1:3]}; // [RULE5]
    // Levels are derived from the live reference, so they move with it.
    wire [SIG_W:0] pos_sum = {1'b0, cur_ref} + {1'b0, thr}; // [RULE3]
    wire [SIG_W-1:0] neg_lvl = (cur_ref > thr) ?
                               cur_ref - thr : '0; // [RULE3]
    wire [SIG_W-1:0] pos_lvl = pos_sum[SIG_W] ? '1 : pos_sum[SIG_W-1:0];
    wire [SIG_W-1:0] pos_keep = pos_lvl - hyst; // [RULE5]

    wire below = (sig < neg_lvl); // [RULE2]
    wire above = (sig > pos_lvl); // [RULE4]
    wire recal_hit = pos_pend[key] && (sig > pos_keep); // [RULE4] [RULE5]
    wire [2:0] drift_code = (sig < cur_ref) ?
                            cur_fall : rising_drift_rate; // [RULE9]
    wire [15:0] elapsed = now_ticks - stamp[key];
    wire drift_due = (elapsed >= tkd_drift_ticks(drift_code));
    wire drift_ok = !below && !touch_o[key] &&
                    (sig != cur_ref) && drift_due; // [RULE8]
    wire eval = (state == ST_EVAL);

    wire [SIG_W-1:0] next_ref = !cal_done[key] ? sig :
                                recal_hit ? sig :
                                !drift_ok ? cur_ref :
                                (sig > cur_ref) ? cur_ref + 12'h001 :
                                cur_ref - 12'h001; // [RULE8]
    wire ref_moves = !cal_done[key] || recal_hit || drift_ok;
    wire next_pend = cal_done[key] && !recal_hit && above;
    wire next_touch = cal_done[key] && below; // [RULE2]

    // Reset clears calibration so each key first takes its signal as
    // the reference on its first scan.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cal_done <= '0;
            pos_pend <= '0;
            touch_o <= '0;
        end else if (eval) begin
            cal_done[key] <= 1'b1;
            pos_pend[key] <= next_pend;
            touch_o[key] <= next_touch;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < KEYS; i++) begin
            if (reset_i) begin
                ref_lvl[i] <= '0;
                stamp[i] <= 16'h0000;
            end else if (eval && ref_moves && key == i[4:0]) begin
                ref_lvl[i] <= next_ref; // [RULE4] [RULE8]
                stamp[i] <= now_ticks;
            end
        end
    end

endmodule : tkd_touch_key

// File: tb/tkd_touch_key_monitor.sv
`timescale 1ns/100ps
module tkd_touch_key_monitor
    import tkd_pkg::*;
#(
    parameter int TICK_LEN = 10
)(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input tkd_reg_req_t reg_req_i,
    input wire logic [SIG_W-1:0] signal_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic setups_unlocked_o,
    input tkd_nv_write_t nv_write_o,
    input wire logic [X_LINES-1:0] x_drive_o,
    input wire logic [Y_LINES-1:0] y_enable_o,
    input wire logic [KEYS-1:0] touch_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    wire unlock_w = reg_req_i.wr && !reg_req_i.rd &&
        reg_req_i.addr == CMD_ADDR && reg_req_i.wdata == CMD_UNLOCK;
    wire in_blk_w = reg_req_i.addr >= SETUP_BASE &&
        reg_req_i.addr <= SETUP_LAST;
    wire setup_wr_w = reg_req_i.wr && !reg_req_i.rd &&
        setups_unlocked_o && in_blk_w;
    wire mapped_wr_w = reg_req_i.wr && setups_unlocked_o &&
        (in_blk_w || reg_req_i.addr == RISE_ADDR);
    sequence s_x_gap;
        !(|x_drive_o) [*3];
    endsequence
    property p_unlock; unlock_w |=> setups_unlocked_o; endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock not taken");
    property p_relock; reg_req_i.rd |=> !setups_unlocked_o; endproperty
    a_relock: assert property (p_relock)
        else $error("read left setups writable");
    property p_lock_stays;
        !unlock_w && !setups_unlocked_o |=> !setups_unlocked_o;
    endproperty
    a_lock_stays: assert property (p_lock_stays)
        else $error("setups unlocked without command");
    property p_nv_data;
        setup_wr_w |=> nv_write_o.stb &&
            nv_write_o.addr == $past(reg_req_i.addr) &&
            nv_write_o.data == $past(reg_req_i.wdata);
    endproperty
    a_nv_data: assert property (p_nv_data)
        else $error("setup write not stored");
    property p_no_nv; !mapped_wr_w |=> !nv_write_o.stb; endproperty
    a_no_nv: assert property (p_no_nv)
        else $error("store strobe without accepted write");
    property p_x_pulse; $rose(|x_drive_o) |=> s_x_gap; endproperty
    a_x_pulse: assert property (p_x_pulse)
        else $error("x pulse wider than one cycle");
    property p_onehot;
        $onehot0(x_drive_o) && $onehot0(y_enable_o);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one line driven");
    property p_touch_one;
        $countones(touch_o ^ $past(touch_o)) <= 1;
    endproperty
    a_touch_one: assert property (p_touch_one)
        else $error("several keys changed at once");
endmodule : tkd_touch_key_monitor

bind tkd_touch_key tkd_touch_key_monitor #(.TICK_LEN(TICK_LEN))
    tkd_touch_key_monitor_inst (.clk_sys_i, .reset_i, .reg_req_i,
    .signal_i, .reg_rdata_o, .setups_unlocked_o, .nv_write_o,
    .x_drive_o, .y_enable_o, .touch_o);

// File: tb/tkd_host_model.sv
`timescale 1ns/100ps
module tkd_host_model
    import tkd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic [7:0] reg_rdata_i,
    output tkd_reg_req_t reg_req_o
);
    initial reg_req_o = '0;
    // Idle address and data are inverted so stale values never pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) #1;
        reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i) #1;
        reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i) #1;
        reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i) #1;
        d = reg_rdata_i;
        reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    endtask : rd
    task automatic unlock();
        wr(CMD_ADDR, CMD_UNLOCK);
    endtask : unlock
endmodule : tkd_host_model

// File: tb/tkd_touch_key_tb_top.sv
`timescale 1ns/100ps
module tkd_touch_key_tb_top
    import tkd_pkg::*;
;
    localparam int TL = 400;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [SIG_W-1:0] signal_i = 12'h3E8;
    tkd_reg_req_t req;
    logic [7:0] rdata;
    logic unl;
    tkd_nv_write_t nvw;
    logic [X_LINES-1:0] xd;
    logic [Y_LINES-1:0] ye;
    logic [KEYS-1:0] touch;
    logic [SIG_W-1:0] sig [KEYS];
    logic [1:0] bl [KEYS];
    int err_count = 0;
    int tests_run = 0;
    int xk = 0;
    int kk = 0;
    int nb = 0;
    int pulses = 0;
    logic xp = 1'b0;
    logic yp = 1'b0;
    logic bl_chk = 1'b0;
    logic [7:0] d;
    always #50 clk_sys_i = ~clk_sys_i;
    tkd_touch_key #(.TICK_LEN(TL)) tkd_touch_key_inst (.clk_sys_i,
        .reset_i, .reg_req_i(req), .signal_i, .reg_rdata_o(rdata),
        .setups_unlocked_o(unl), .nv_write_o(nvw), .x_drive_o(xd),
        .y_enable_o(ye), .touch_o(touch));
    tkd_host_model tkd_host_model_inst (.clk_sys_i,
        .reg_rdata_i(rdata), .reg_req_o(req));
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        tkd_host_model_inst.rd(a, d);
        chk($sformatf("read %0h", a), e, d);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] v,
        input logic s);
        tkd_host_model_inst.wr(a, v);
        chk("store strobe", s, nvw.stb);
        if (s) chk("store byte", {a, v}, {nvw.addr, nvw.data});
    endtask : wr
    task automatic wait_bursts(input int n);
        int t;
        t = nb + n;
        for (int i = 0; i < n * 400 && nb < t; i++) @(posedge clk_sys_i);
        #1;
        if (nb < t) begin
            err_count++;
            final_report();
        end
    endtask : wait_bursts
    // -------------------------------------------------------------
    // Key tracking: the key under burst is known from its X and Y.
    // -------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        #1;
        if (|xd) xk = $clog2(xd);
        if (|xd && !xp) pulses++;
        if (!(|ye) && yp) begin
            if (bl_chk) chk("pulses", 16 * (bl[kk] + 1), pulses);
            pulses = 0;
        end
        if (|ye && !yp) nb++;
        if (|ye) kk = $clog2(ye) * 8 + xk;
        xp = |xd;
        yp = |ye;
        signal_i = sig[kk];
    end
    initial begin
        for (int k = 0; k < KEYS; k++) begin
            sig[k] = 12'h3E8;
            bl[k] = 2'h2;
        end
        repeat (10) @(posedge clk_sys_i);
        #1 reset_i = 1'b0;
        rd(SETUP_BASE, 8'hA3);
        rd(SETUP_LAST, 8'hA3);
        rd(RISE_ADDR, 8'h04);
        rd(8'h05, 8'h00);
        wr(SETUP_BASE, 8'h00, 1'b0);
        rd(SETUP_BASE, 8'hA3);
        tkd_host_model_inst.unlock();
        chk("unlocked", 1'b1, unl);
        // Burst codes cycle 0 to 3 across the keys; ten-count thresholds keep noise margin.
        for (int k = 0; k < KEYS; k++) begin
            d = {2'(k), (k == 5 || k == 8) ? 3'h0 : 3'h7, 3'h3};
            wr(SETUP_BASE + 8'(k), d, 1'b1);
            bl[k] = 2'(k);
        end
        wr(RISE_ADDR, 8'h00, 1'b1);
        wr(8'hA5, 8'h55, 1'b0);
        rd(SETUP_BASE + 8'h02, 8'hBB);
        chk("unlocked", 1'b0, unl);
        wr(SETUP_BASE, 8'h00, 1'b0);
        wait_bursts(2);
        bl_chk = 1'b1;
        wait_bursts(48);
        sig[5] = 12'h3DD;
        sig[6] = 12'h3DE;
        sig[7] = 12'h3FC;
        sig[8] = 12'h3E3;
        sig[9] = 12'h3E3;
        wait_bursts(72);
        chk("touch 5", 1'b1, touch[5]);
        chk("touch 6", 1'b0, touch[6]);
        sig[7] = 12'h3F1;
        sig[8] = 12'h3DD;
        sig[9] = 12'h3DD;
        wait_bursts(48);
        chk("touch 7", 1'b1, touch[7]);
        chk("touch 8", 1'b0, touch[8]);
        chk("touch 9", 1'b1, touch[9]);
        chk("touch 5", 1'b1, touch[5]);
        final_report();
    end
endmodule : tkd_touch_key_tb_top
